/* File: src/cmd_frame_pkg.sv */
// Purpose: Constants for the command frame encoder
// Assumes: 25 MHz clock, APB register access
// Notes:   Byte addresses of one-word registers
package cmd_frame_pkg;
   // Clock and timing
   localparam int CLK_HZ        = 25_000_000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int HALF_BIT_NS   = 5000;
   localparam int HALF_CYC      = HALF_BIT_NS / CLK_PERIOD_NS;
   localparam int FRAME_RATE_MIN = 50;
   localparam int CMD_LIMIT_MS   = 50;
   localparam int FRAME_MAX_CYC_DEF = CLK_HZ / FRAME_RATE_MIN;
   localparam int CMD_MAX_CYC_DEF   = (CLK_HZ / 1000) * CMD_LIMIT_MS;
   localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

   // Frame layout
   localparam int FRAME_BITS = 80;
   localparam int SYNC_BITS  = 16;
   localparam int KEY_BITS   = 64;
   localparam logic [15:0] SYNC_WORD = 16'hEB90;
   localparam logic [6:0]  LAST_BIT  = 7'(FRAME_BITS - 1);
   localparam logic [6:0]  SYNC_END  = 7'(SYNC_BITS);

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_RANGE   = 8'h04;
   localparam logic [7:0] ADDR_TXID    = 8'h08;
   localparam logic [7:0] ADDR_VEHICLE = 8'h0C;
   localparam logic [7:0] ADDR_CMD     = 8'h10;
   localparam logic [7:0] ADDR_COUNT   = 8'h14;
   localparam logic [7:0] ADDR_STATUS  = 8'h18;

   // Status fields
   localparam int STAT_PEND    = 0;
   localparam int STAT_ONAIR   = 1;
   localparam int STAT_RUN     = 2;
   localparam int STAT_KEY_LSB = 4;
   localparam int STAT_CNT_LSB = 16;
endpackage

/* File: src/cmd_frame_encoder.sv */
// Purpose: Command frame encoder with Manchester baseband output
// Assumes: Synchronous inputs, APB master per protocol
// Notes:   Frame = sync word then payload xored with loaded key
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cmd_frame_encoder
   import cmd_frame_pkg::*;
#(
   parameter int FRAME_MAX_CYC = cmd_frame_pkg::FRAME_MAX_CYC_DEF,
   parameter int CMD_MAX_CYC   = cmd_frame_pkg::CMD_MAX_CYC_DEF
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Key transfer unit
   input  wire logic        key_valid,
   input  wire logic [7:0]  key_data,
   output logic             key_ready,
   // Baseband and monitors
   output logic             baseband,
   output logic             mon_cmd_write,
   output logic             mon_frame_sync,
   output logic             mon_cmd_frame,
   output logic             mon_frame_end
);
   import cmd_frame_pkg::*;

   typedef struct packed {
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      logic                  enable;
      logic [15:0]           range_identifier_field;
      logic [3:0]            transmitter_identifier_field;
      logic [19:0]           vehicle_identifier_field;
      logic [4:0]            user_cmd;
      logic [11:0]           cnt_set;
      logic                  cnt_set_pend;
      logic                  cmd_pend;
      logic [11:0]           cnt;
      logic                  running;
      logic [FRAME_BITS-1:0] frame;
      logic [6:0]            bit_idx;
      logic [7:0]            half_cnt;
      logic                  half;
      logic                  cmd_frame;
      logic                  line;
      logic                  mon_sync;
      logic                  mon_end;
      logic                  mon_wr;
      logic                  key_ready;
      logic [KEY_BITS-1:0]   key;
      logic [3:0]            key_cnt;
   } state_s;

   state_s q, d;
   logic   mid, bit_end, last, start, rd_req, wr_go;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d       = q;
      d.mon_end = 1'b0;
      d.mon_wr  = 1'b0;
      mid     = q.running && q.half_cnt == HALF_LAST && !q.half;
      bit_end = q.running && q.half_cnt == HALF_LAST && q.half;
      last    = bit_end && q.bit_idx == LAST_BIT;
      start   = q.enable && (last || !q.running);
      rd_req  = psel && penable && !q.pready;
      wr_go   = psel && penable && q.pready && pwrite;

      // Bit timing from an exact count
      if (q.running) begin
         d.half_cnt = (q.half_cnt == HALF_LAST) ? 8'h00 : q.half_cnt + 8'h01;
      end
      if (mid) begin
         d.half = 1'b1;
         d.line = !q.line;
      end
      if (bit_end) begin
         d.half    = 1'b0;
         d.bit_idx = q.bit_idx + 7'h01;
         d.frame   = {q.frame[FRAME_BITS-2:0], 1'b0};
         d.line    = q.frame[FRAME_BITS-2];
      end
      if (last) begin
         d.mon_end   = 1'b1;
         d.cmd_frame = 1'b0;
         if (q.cmd_frame) begin
            d.cnt = q.cnt + 12'h001;
         end
      end

      // Frame boundary capture
      if (start) begin
         if (q.cnt_set_pend) begin
            d.cnt          = q.cnt_set;
            d.cnt_set_pend = 1'b0;
         end
         d.cmd_frame = q.cmd_pend;
         d.cmd_pend  = 1'b0;
         d.frame     = {SYNC_WORD, {q.range_identifier_field, q.transmitter_identifier_field,
                        q.vehicle_identifier_field, q.user_cmd, d.cnt, 7'h00} ^ q.key};
         d.running   = 1'b1;
         d.bit_idx   = 7'h00;
         d.half      = 1'b0;
         d.half_cnt  = 8'h00;
         d.line      = SYNC_WORD[15];
      end else if (last) begin
         d.running = 1'b0;
         d.line    = 1'b0;
      end

      // Key loading while stopped
      if (key_valid && q.key_ready) begin
         d.key     = {q.key[KEY_BITS-9:0], key_data};
         d.key_cnt = q.key_cnt + 4'h1;
      end

      // APB read answer
      d.pready = rd_req;
      if (rd_req) begin
         d.pslverr = 1'b0;
         d.prdata  = 32'h0000_0000;
         if (paddr == ADDR_CTRL) begin
            d.prdata[0] = q.enable;
         end else if (paddr == ADDR_RANGE) begin
            d.prdata[15:0] = q.range_identifier_field;
         end else if (paddr == ADDR_TXID) begin
            d.prdata[3:0] = q.transmitter_identifier_field;
         end else if (paddr == ADDR_VEHICLE) begin
            d.prdata[19:0] = q.vehicle_identifier_field;
         end else if (paddr == ADDR_CMD) begin
            d.prdata[4:0] = q.user_cmd;
         end else if (paddr == ADDR_COUNT) begin
            d.prdata[11:0] = q.cnt_set;
         end else if (paddr == ADDR_STATUS) begin
            d.prdata[STAT_PEND]                  = q.cmd_pend;
            d.prdata[STAT_ONAIR]                 = q.cmd_frame;
            d.prdata[STAT_RUN]                   = q.running;
            d.prdata[STAT_KEY_LSB+3:STAT_KEY_LSB] = q.key_cnt;
            d.prdata[STAT_CNT_LSB+11:STAT_CNT_LSB] = q.cnt;
         end else begin
            d.pslverr = 1'b1;
         end
      end else begin
         d.pslverr = 1'b0;
      end

      // APB write, after capture so a set wins over the clear
      if (wr_go) begin
         if (paddr == ADDR_CTRL) begin
            d.enable = pwdata[0];
         end else if (paddr == ADDR_RANGE) begin
            d.range_identifier_field = pwdata[15:0];
         end else if (paddr == ADDR_TXID) begin
            d.transmitter_identifier_field = pwdata[3:0];
         end else if (paddr == ADDR_VEHICLE) begin
            d.vehicle_identifier_field = pwdata[19:0];
         end else if (paddr == ADDR_CMD) begin
            d.user_cmd = pwdata[4:0];
            d.cmd_pend = 1'b1;
            d.mon_wr   = 1'b1;
         end else if (paddr == ADDR_COUNT) begin
            d.cnt_set      = pwdata[11:0];
            d.cnt_set_pend = 1'b1;
         end
      end

      d.key_ready = !d.enable && !d.running;
      d.mon_sync  = d.running && d.bit_idx < SYNC_END;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pready         = q.pready;
   assign prdata         = q.prdata;
   assign pslverr        = q.pslverr;
   assign key_ready      = q.key_ready;
   assign baseband       = q.line;
   assign mon_cmd_write  = q.mon_wr;
   assign mon_frame_sync = q.mon_sync;
   assign mon_cmd_frame  = q.cmd_frame;
   assign mon_frame_end  = q.mon_end;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [20:0] gap_q;
   logic [20:0] wait_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gap_q  <= '0;
         wait_q <= '0;
      end else begin
         gap_q  <= (!q.running || q.mon_end) ? 21'h0 : gap_q + 21'h1;
         wait_q <= (q.cmd_pend || q.cmd_frame) ? wait_q + 21'h1 : 21'h0;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   chk_mid_bit_toggle: assert property (mid |=> baseband != $past(baseband))
      else $error("no mid-bit transition");
   chk_frame_gap_max: assert property (gap_q <= 21'(FRAME_MAX_CYC))
      else $error("frame period too long");
   chk_range_field: assert property (start |=> (q.frame[63:48] ^ q.key[63:48])
      == $past(q.range_identifier_field))
      else $error("range field wrong");
   chk_txid_field: assert property (start |=> (q.frame[47:44] ^ q.key[47:44])
      == $past(q.transmitter_identifier_field))
      else $error("transmitter field wrong");
   chk_vehicle_field: assert property (start |=> (q.frame[43:24] ^ q.key[43:24])
      == $past(q.vehicle_identifier_field))
      else $error("vehicle field wrong");
   chk_user_field: assert property (start |=> (q.frame[23:19] ^ q.key[23:19])
      == $past(q.user_cmd))
      else $error("user field wrong");
   chk_count_step: assert property (last && q.cmd_frame && !q.cnt_set_pend
      |=> q.cnt == $past(q.cnt) + 12'h001)
      else $error("counter did not step");
   chk_count_load: assert property (start && q.cnt_set_pend |=> q.cnt == $past(q.cnt_set))
      else $error("counter not loaded");
   chk_stream_steady: assert property (q.running && q.enable |=> q.running)
      else $error("stream interrupted");
   chk_cmd_latency: assert property (wait_q <= 21'(CMD_MAX_CYC))
      else $error("command too slow");
   chk_end_pulse: assert property (last |=> mon_frame_end ##1 !mon_frame_end)
      else $error("frame end pulse wrong");
   chk_edge_spacing: assert property (q.running && $past(q.running) && $changed(baseband)
      |-> $past(q.half_cnt) == HALF_LAST)
      else $error("edge off the bit grid");
   chk_key_shift: assert property (key_valid && key_ready |=> q.key[7:0] == $past(key_data))
      else $error("key byte lost");
   chk_fields_hold: assert property (!start |=> q.cnt == $past(q.cnt) || $past(last))
      else $error("counter moved mid-frame");
   chk_sync_word: assert property (start |=> q.frame[79:64] == SYNC_WORD ##1 mon_frame_sync)
      else $error("sync word missing");

   ////////////////////////////////////////////////////////////////////////
   // Bit grid checks
   chk_half_range: assert property (
      q.half_cnt <= HALF_LAST)
      else $error("half-bit count out of range");
   chk_half_toggle: assert property (
      mid |=> q.half)
      else $error("half flag not set at mid-bit");
   chk_bit_step: assert property (
      bit_end && !last |=> q.bit_idx == $past(q.bit_idx) + 7'h01)
      else $error("bit index did not step");
   chk_line_at_bit: assert property (
      bit_end && !last |=> baseband == $past(q.frame[FRAME_BITS-2]))
      else $error("bit level wrong at bit start");
   chk_idle_low: assert property (
      !q.running |-> !baseband)
      else $error("line not low while idle");

   // Frame flow checks
   chk_enable_start: assert property (
      q.enable && !q.running |=> q.running)
      else $error("enabled encoder did not start");
   chk_end_index: assert property (
      mon_frame_end |-> $past(q.bit_idx) == LAST_BIT)
      else $error("frame end at wrong bit");
   chk_sync_length: assert property (
      $fell(mon_frame_sync) |-> q.bit_idx == SYNC_END)
      else $error("sync monitor wrong length");
   chk_cmd_frame_hold: assert property (
      mon_cmd_frame && !last |=> mon_cmd_frame)
      else $error("command frame monitor dropped");

   // Command and key checks
   chk_wr_after_write: assert property (
      wr_go && paddr == ADDR_CMD |=> mon_cmd_write)
      else $error("no command write pulse");
   chk_wr_pulse: assert property (
      mon_cmd_write |=> !mon_cmd_write)
      else $error("command write pulse too long");
   chk_cmd_pend_set: assert property (
      wr_go && paddr == ADDR_CMD |=> q.cmd_pend)
      else $error("command not marked pending");
   chk_key_gate: assert property (
      key_ready |-> !q.enable && !q.running)
      else $error("key port open while sending");
   chk_key_frozen: assert property (
      q.running |=> q.key == $past(q.key))
      else $error("key changed mid-frame");

   // Register bus checks
   chk_ready_pulse: assert property (
      pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_ready_timing: assert property (
      psel && penable && !pready |=> pready)
      else $error("ready not one cycle after access");
   chk_err_data: assert property (
      pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error without ready or with data");
   chk_read_err: assert property (
      rd_req && paddr > ADDR_STATUS |=> pslverr)
      else $error("unmapped read not refused");
   chk_status_run: assert property (
      rd_req && paddr == ADDR_STATUS |=> prdata[STAT_RUN] == $past(q.running))
      else $error("status run bit wrong");

   cov_cmd_frame: cover property (mon_cmd_write ##[1:1000] start ##1 mon_cmd_frame);
   cov_disable_stop: cover property (last && !q.enable);
   cov_key_load: cover property (key_valid && key_ready);
   cov_count_load: cover property (start && q.cnt_set_pend);
   cov_err_read: cover property (pready && pslverr);
endmodule // cmd_frame_encoder
`default_nettype wire

/* File: tb/link_receiver.sv */
// Purpose: Far-side link receiver model that decodes baseband frames
// Assumes: 125-cycle half bits, frame start marked by the sync monitor
// Notes:   Samples each half bit near its middle, MSB first
`timescale 1ns/1ps
`default_nettype none
module link_receiver (
   // Clock
   input  wire logic        clock,
   // Link
   input  wire logic        baseband,
   input  wire logic        frame_sync,
   // Decoded result
   output logic [79:0]      bits,
   output int               frames,
   output int               mid_bad
);
   logic first;
   initial begin
      bits = '0;
      frames = 0;
      mid_bad = 0;
      forever begin
         @(posedge frame_sync);
         for (int i = 0; i < 80; i++) begin
            repeat (62) @(posedge clock);
            first = baseband;
            repeat (125) @(posedge clock);
            if (baseband === first) mid_bad++;
            bits = {bits[78:0], first};
            if (i < 79) repeat (63) @(posedge clock);
         end
         frames++;
      end
   end
endmodule // link_receiver
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the command frame encoder
// Assumes: Shortened bound parameters, APB master per protocol
// Notes:   Three frames are decoded by the link receiver model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cmd_frame_pkg::*;
   localparam logic [63:0] KEY = 64'h1122334455667788;
   logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0, key_data = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, key_valid = 0, key_ready, baseband, er;
   logic mon_cmd_write, mon_frame_sync, mon_cmd_frame, mon_frame_end;
   logic cmd_seen = 0, cmd_last = 0, wr_seen = 0;
   logic [79:0] bits;
   int frames, mid_bad, bad_count = 0, samples_checked = 0, cyc = 0, gap = 0, last_gap = 0;
   always #20 clock = ~clock;
   cmd_frame_encoder #(.FRAME_MAX_CYC(21000), .CMD_MAX_CYC(45000)) uut (.clock(clock),
      .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .key_valid(key_valid), .key_data(key_data), .key_ready(key_ready),
      .baseband(baseband), .mon_cmd_write(mon_cmd_write), .mon_frame_sync(mon_frame_sync),
      .mon_cmd_frame(mon_cmd_frame), .mon_frame_end(mon_frame_end));
   link_receiver rx (.clock(clock), .baseband(baseband), .frame_sync(mon_frame_sync),
      .bits(bits), .frames(frames), .mid_bad(mid_bad));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      wr_seen <= wr_seen | mon_cmd_write;
      gap <= mon_frame_end ? 0 : gap + 1;
      cmd_seen <= mon_frame_end ? 1'b0 : (cmd_seen | mon_cmd_frame);
      if (mon_frame_end) begin
         last_gap <= gap + 1;
         cmd_last <= cmd_seen;
      end
      if (cyc == 80000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_end();
      do @(posedge clock); while (mon_frame_end !== 1'b1);
      @(negedge clock);
   endtask
   function automatic logic [79:0] fr(input logic [15:0] rg, input logic [11:0] cn);
      return {SYNC_WORD, {rg, 4'hF, 20'hFFFFF, 5'h1F, cn, 7'h00} ^ KEY};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] ad [4] = '{ADDR_RANGE, ADDR_TXID, ADDR_VEHICLE, ADDR_CMD};
      logic [31:0] mk [4] = '{32'h0000FFFF, 32'h0000000F, 32'h000FFFFF, 32'h0000001F};
      for (int i = 0; i < 4; i++) begin
         apb(0, ad[i], '0);
         chk(rd, 80'h0);
         apb(1, ad[i], 32'hFFFFFFFF);
         apb(0, ad[i], '0);
         chk(rd, mk[i]);
      end
      apb(0, 8'h1C, '0);
      chk({er, rd}, {1'b1, 32'h0});
      chk(wr_seen, 1'b1);
   endtask
   task automatic t_key();
      for (int i = 0; i < 10 && key_ready !== 1'b1; i++) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         key_valid <= 1;
         key_data <= 8'(17 * (i + 1));
         @(posedge clock);
      end
      key_valid <= 0;
      apb(0, ADDR_STATUS, '0);
      chk(rd[7:4], 4'h8);
   endtask
   task automatic t_frames();
      apb(1, ADDR_COUNT, 32'h00000FFF);
      apb(1, ADDR_CTRL, 32'h1);
      while (frames < 1) @(posedge clock);
      chk(bits, fr(16'hFFFF, 12'hFFF));
      wait_end();
      apb(0, ADDR_STATUS, '0);
      chk(rd[27:16], 12'h000);
      chk(rd[2:0], 3'b100);
      chk(cmd_last, 1'b1);
      apb(1, ADDR_RANGE, 32'h1234);
      while (frames < 2) @(posedge clock);
      chk(bits, fr(16'hFFFF, 12'h000));
      wait_end();
      chk(last_gap, 20000);
      chk(cmd_last, 1'b0);
      while (frames < 3) @(posedge clock);
      chk(bits, fr(16'h1234, 12'h000));
      chk(mid_bad, 0);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1;
      t_regs();
      t_key();
      t_frames();
      summarize();
   end
endmodule // testbench
`default_nettype wire
